//--- core/gpm_gpio_port.sv
// Purpose: Fifteen-pad port with function select, atomic set/clear,
//          pad interrupts and timer capture routing, behind APB.
// Assumes: Single clock; serial peripherals on the same clock.
// Notes: Zero-wait APB; read data sampled in the setup cycle.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
`include "gpm_regs.svh"
module gpm_gpio_port
    import gpm_pkg::*;
#(
    parameter int PADS = `GPM_PADS
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Pads
    input wire logic [PADS-1:0] i_pad_in,
    output logic [PADS-1:0] o_pad_out,
    output logic [PADS-1:0] o_pad_oe,
    output logic [PADS-1:0] o_pad_drive_high,
    // Serial peripherals
    input wire logic [PADS-1:0] i_serial_function_0_out,
    input wire logic [PADS-1:0] i_serial_function_0_oe,
    input wire logic [PADS-1:0] i_serial_function_1_out,
    input wire logic [PADS-1:0] i_serial_function_1_oe,
    input wire logic [PADS-1:0] i_serial_function_2_out,
    input wire logic [PADS-1:0] i_serial_function_2_oe,
    output logic [PADS-1:0] o_pad_level,
    // Timer capture inputs
    output logic o_timer1_input_a,
    output logic o_timer1_input_b,
    output logic o_timer2_input_a,
    output logic o_timer2_input_b,
    // Interrupt
    output logic o_irq
);
    // Struct widths are fixed by the header, so other counts cannot be served
    if (PADS != `GPM_PADS) begin : g_bad_pads
        $error("gpm_gpio_port: pad count must match the register header");
    end

    localparam gpm_state_t RST_STATE = '{
        func_low: `GPM_RST_FUNC_LOW,
        func_high: `GPM_RST_FUNC_HIGH,
        routing: `GPM_RST_ROUTING,
        default: '0
    };

    gpm_state_t st;
    gpm_state_t next_st;
    logic [PADS-1:0] pad_level;
    logic [PADS-1:0] pending;
    logic [PADS-1:0] masked;
    logic [PADS-1:0] is_gpio;
    logic [PADS-1:0] pad_out_mux;
    logic [PADS-1:0] pad_oe_mux;
    logic [PADS-1:0] wdata_pads;
    logic [PADS-1:0] irq_clear_pulse;
    logic [PADS-1:0] set_bits;
    logic [PADS-1:0] clr_bits;
    logic [3:0] timer_pick;
    logic [7:0] addr_w;
    logic setup_phase;
    logic access_phase;
    logic wr_access;
    logic [31:0] rd_word;
    logic rd_hit;

    function automatic logic [31:0] pad_word(input logic [PADS-1:0] v);
        pad_word = {{(32 - PADS){1'b0}}, v};
    endfunction

    gpm_sync #(
        .W(PADS)
    ) u_sync (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_d(i_pad_in),
        .o_q(pad_level)
    );

    gpm_irq_detect #(
        .W(PADS)
    ) u_detect (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_level(pad_level),
        .i_sense(st.sense),
        .i_both(st.both),
        .i_polarity(st.polarity),
        .i_clear(irq_clear_pulse),
        .o_pending(pending)
    );

    assign addr_w = {i_paddr[7:2], 2'h0};
    assign setup_phase = i_psel && !i_penable;
    assign access_phase = i_psel && i_penable;
    assign wr_access = access_phase && i_pwrite;
    assign wdata_pads = i_pwdata[PADS-1:0];
    assign masked = pending & st.mask;
    assign irq_clear_pulse = (wr_access && addr_w == `GPM_OFS_IRQ_CLEAR)
        ? wdata_pads : '0;
    assign set_bits = wdata_pads & is_gpio;
    assign clr_bits = wdata_pads & is_gpio;

    // Per-pad function decode and output selection
    for (genvar p = 0; p < PADS; p++) begin : g_pad
        logic [2:0] func;
        if (p < `GPM_PADS_PER_WORD) begin : g_low
            assign func = st.func_low[`GPM_NIBBLE*p +: `GPM_FUNC_W];
        end else begin : g_high
            assign func = st.func_high[`GPM_NIBBLE*(p-`GPM_PADS_PER_WORD) +: `GPM_FUNC_W];
        end
        assign is_gpio[p] = (func == `GPM_FUNC_GPIO);
        always_comb begin
            // Unused codes leave the pad undriven
            case (func)
                `GPM_FUNC_GPIO: begin
                    pad_out_mux[p] = st.data[p];
                    pad_oe_mux[p] = st.direction[p];
                end
                `GPM_FUNC_SERIAL_FUNCTION_0: begin
                    pad_out_mux[p] = i_serial_function_0_out[p];
                    pad_oe_mux[p] = i_serial_function_0_oe[p];
                end
                `GPM_FUNC_SERIAL_FUNCTION_1: begin
                    pad_out_mux[p] = i_serial_function_1_out[p];
                    pad_oe_mux[p] = i_serial_function_1_oe[p];
                end
                `GPM_FUNC_SERIAL_FUNCTION_2: begin
                    pad_out_mux[p] = i_serial_function_2_out[p];
                    pad_oe_mux[p] = i_serial_function_2_oe[p];
                end
                default: begin
                    pad_out_mux[p] = 1'b0;
                    pad_oe_mux[p] = 1'b0;
                end
            endcase
        end
    end

    // Timer capture routing; out-of-range index reads low
    for (genvar t = 0; t < 4; t++) begin : g_route
        logic [7:0] sel;
        assign sel = st.routing[`GPM_ROUTE_W*t +: `GPM_ROUTE_W];
        assign timer_pick[t] = (sel < 8'(PADS)) ? pad_level[sel[3:0]] : 1'b0;
    end

    // Read decode; write-only and set/clear words read as zero
    always_comb begin
        rd_word = 32'h00000000;
        rd_hit = 1'b1;
        case (addr_w)
            `GPM_OFS_DATA: rd_word = pad_word(pad_level);
            `GPM_OFS_DIRECTION: rd_word = pad_word(st.direction);
            `GPM_OFS_DRIVE: rd_word = pad_word(st.drive);
            `GPM_OFS_SENSE: rd_word = pad_word(st.sense);
            `GPM_OFS_BOTH: rd_word = pad_word(st.both);
            `GPM_OFS_POLARITY: rd_word = pad_word(st.polarity);
            `GPM_OFS_MASK: rd_word = pad_word(st.mask);
            `GPM_OFS_RAW_STATUS: rd_word = pad_word(pending);
            `GPM_OFS_MASKED_STATUS: rd_word = pad_word(masked);
            `GPM_OFS_IRQ_CLEAR: rd_word = 32'h00000000;
            `GPM_OFS_FUNC_LOW: rd_word = st.func_low;
            `GPM_OFS_FUNC_HIGH: rd_word = st.func_high;
            `GPM_OFS_SET: rd_word = 32'h00000000;
            `GPM_OFS_CLEAR: rd_word = 32'h00000000;
            `GPM_OFS_ROUTING: rd_word = st.routing;
            default: rd_hit = 1'b0;
        endcase
    end

    always_comb begin
        next_st = st;
        if (setup_phase) begin
            next_st.prdata = rd_word;
            next_st.pslverr = !rd_hit;
        end
        // Unmapped writes are dropped; read-only words ignore writes
        if (wr_access && !st.pslverr) begin
            case (addr_w)
                `GPM_OFS_DATA: next_st.data = wdata_pads;
                `GPM_OFS_DIRECTION: next_st.direction = wdata_pads;
                `GPM_OFS_DRIVE: next_st.drive = wdata_pads;
                `GPM_OFS_SENSE: next_st.sense = wdata_pads;
                `GPM_OFS_BOTH: next_st.both = wdata_pads;
                `GPM_OFS_POLARITY: next_st.polarity = wdata_pads;
                `GPM_OFS_MASK: next_st.mask = wdata_pads;
                // Reserved bits are dropped, so a stray write cannot stick
                `GPM_OFS_FUNC_LOW: next_st.func_low = i_pwdata & `GPM_FUNC_LOW_MASK;
                `GPM_OFS_FUNC_HIGH: next_st.func_high = i_pwdata & `GPM_FUNC_HIGH_MASK;
                `GPM_OFS_SET: next_st.data = st.data | set_bits;
                `GPM_OFS_CLEAR: next_st.data = st.data & ~clr_bits;
                `GPM_OFS_ROUTING: next_st.routing = i_pwdata;
                default: next_st.data = st.data;
            endcase
        end
        next_st.pad_out = pad_out_mux;
        next_st.pad_oe = pad_oe_mux;
        next_st.timer_in = timer_pick;
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st <= RST_STATE;
        end else begin
            st <= next_st;
        end
    end

    assign o_prdata = st.prdata;
    assign o_pready = 1'b1;
    assign o_pslverr = st.pslverr && access_phase;
    assign o_pad_out = st.pad_out;
    assign o_pad_oe = st.pad_oe;
    assign o_pad_drive_high = st.drive;
    assign o_pad_level = pad_level;
    assign o_timer1_input_a = st.timer_in[0];
    assign o_timer1_input_b = st.timer_in[1];
    assign o_timer2_input_a = st.timer_in[2];
    assign o_timer2_input_b = st.timer_in[3];
    assign o_irq = |masked;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    sequence s_setup_at(logic [7:0] a);
        setup_phase && addr_w == a;
    endsequence

    sequence s_write_at(logic [7:0] a);
        wr_access && addr_w == a && !st.pslverr;
    endsequence

    a_set_raises: assert property (s_write_at(`GPM_OFS_SET)
        |=> (st.data & $past(set_bits)) == $past(set_bits)) else $error("set bit missing");
    a_set_keeps: assert property (s_write_at(`GPM_OFS_SET)
        |=> ((st.data ^ $past(st.data)) & ~$past(set_bits)) == '0)
        else $error("set touched other bits");
    a_clear_lowers: assert property (s_write_at(`GPM_OFS_CLEAR)
        |=> (st.data & $past(clr_bits)) == '0) else $error("clear bit left high");
    a_drive_write: assert property (s_write_at(`GPM_OFS_DRIVE)
        |=> o_pad_drive_high == $past(wdata_pads)) else $error("drive not updated");
    a_masked_read: assert property (s_setup_at(`GPM_OFS_MASKED_STATUS)
        |=> o_prdata == pad_word($past(masked))) else $error("masked status wrong");
    a_irq_gate: assert property (o_irq |-> (pending & st.mask) != '0)
        else $error("irq without masked bit");
    a_mask_block: assert property (s_write_at(`GPM_OFS_MASK) ##0 i_pwdata == 32'h00000000
        |=> !o_irq) else $error("masked pad raised irq");
    a_func_reset: assert property ($past(i_rst) |-> st.func_high == `GPM_RST_FUNC_HIGH
        && st.func_low == `GPM_RST_FUNC_LOW) else $error("function reset wrong");
    a_unmapped_err: assert property (setup_phase && !rd_hit ##1 access_phase
        |-> o_pslverr) else $error("unmapped address accepted");
    a_route_pick: assert property (st.routing[7:0] < 8'(PADS) && $stable(st.routing)
        |=> o_timer1_input_a == $past(pad_level[st.routing[3:0]]))
        else $error("routing wrong");
    a_dir_write: assert property (s_write_at(`GPM_OFS_DIRECTION)
        |=> st.direction == $past(wdata_pads)) else $error("direction not stored");
    a_sense_write: assert property (s_write_at(`GPM_OFS_SENSE)
        |=> st.sense == $past(wdata_pads)) else $error("sense not stored");
    a_both_write: assert property (s_write_at(`GPM_OFS_BOTH)
        |=> st.both == $past(wdata_pads)) else $error("both-edge not stored");
    a_pol_write: assert property (s_write_at(`GPM_OFS_POLARITY)
        |=> st.polarity == $past(wdata_pads)) else $error("polarity not stored");
    a_mask_write: assert property (s_write_at(`GPM_OFS_MASK)
        |=> st.mask == $past(wdata_pads)) else $error("mask not stored");
    a_route_write: assert property (s_write_at(`GPM_OFS_ROUTING)
        |=> st.routing == $past(i_pwdata)) else $error("routing not stored");
    a_func_low_keep: assert property (s_write_at(`GPM_OFS_FUNC_LOW)
        |=> st.func_low == ($past(i_pwdata) & `GPM_FUNC_LOW_MASK))
        else $error("low function wrong");
    a_func_high_keep: assert property (s_write_at(`GPM_OFS_FUNC_HIGH)
        |=> st.func_high == ($past(i_pwdata) & `GPM_FUNC_HIGH_MASK))
        else $error("high function wrong");
    a_clear_keeps: assert property (s_write_at(`GPM_OFS_CLEAR)
        |=> ((st.data ^ $past(st.data)) & ~$past(clr_bits)) == '0)
        else $error("clear touched other bits");
    a_read_data: assert property (s_setup_at(`GPM_OFS_DATA)
        |=> o_prdata == pad_word($past(pad_level))) else $error("pad level read wrong");
    a_read_dir: assert property (s_setup_at(`GPM_OFS_DIRECTION)
        |=> o_prdata == pad_word($past(st.direction))) else $error("direction read wrong");
    a_read_route: assert property (s_setup_at(`GPM_OFS_ROUTING)
        |=> o_prdata == $past(st.routing)) else $error("routing read wrong");
    a_read_func: assert property (s_setup_at(`GPM_OFS_FUNC_HIGH)
        |=> o_prdata == $past(st.func_high)) else $error("high function read wrong");

    for (genvar t = 0; t < 4; t++) begin : g_route_chk
        a_route_index: assert property (g_route[t].sel < 8'(PADS)
            |=> st.timer_in[t] == $past(pad_level[g_route[t].sel[3:0]]))
            else $error("capture pad wrong");
        a_route_range: assert property (g_route[t].sel >= 8'(PADS) |=> !st.timer_in[t])
            else $error("capture out of range");
    end

    for (genvar p = 0; p < PADS; p++) begin : g_pad_chk
        a_gpio_drive: assert property (is_gpio[p] && st.direction[p]
            |=> o_pad_oe[p] && o_pad_out[p] == $past(st.data[p])) else $error("pad not driven");
        a_gpio_input: assert property (is_gpio[p] && !st.direction[p]
            |=> !o_pad_oe[p]) else $error("input pad driven");
        a_serial_function_0_mux: assert property (g_pad[p].func == `GPM_FUNC_SERIAL_FUNCTION_0
            |=> o_pad_out[p] == $past(i_serial_function_0_out[p]) && o_pad_oe[p] == $past(i_serial_function_0_oe[p]))
            else $error("serial 0 not routed");
        a_serial_function_1_mux: assert property (g_pad[p].func == `GPM_FUNC_SERIAL_FUNCTION_1
            |=> o_pad_out[p] == $past(i_serial_function_1_out[p]) && o_pad_oe[p] == $past(i_serial_function_1_oe[p]))
            else $error("serial 1 not routed");
        a_serial_function_2_mux: assert property (g_pad[p].func == `GPM_FUNC_SERIAL_FUNCTION_2
            |=> o_pad_out[p] == $past(i_serial_function_2_out[p]) && o_pad_oe[p] == $past(i_serial_function_2_oe[p]))
            else $error("serial 2 not routed");
        a_unused_off: assert property (!is_gpio[p] && g_pad[p].func != `GPM_FUNC_SERIAL_FUNCTION_0
            && g_pad[p].func != `GPM_FUNC_SERIAL_FUNCTION_1 && g_pad[p].func != `GPM_FUNC_SERIAL_FUNCTION_2
            |=> !o_pad_oe[p] && !o_pad_out[p]) else $error("unused code drives pad");
        a_rise_hit: assert property (!$past(i_rst) && !st.sense[p] && st.polarity[p]
            && $rose(pad_level[p]) |=> pending[p]) else $error("rising edge missed");
        a_fall_hit: assert property (!$past(i_rst) && !st.sense[p]
            && (!st.polarity[p] || st.both[p]) && $fell(pad_level[p])
            |=> pending[p]) else $error("falling edge missed");
        a_level_again: assert property (st.sense[p] && st.polarity[p] == pad_level[p]
            ##0 s_write_at(`GPM_OFS_IRQ_CLEAR) |=> pending[p]) else $error("level status lost");
    end
endmodule

//--- core/gpm_regs.svh
// Purpose: Register offsets, reset values and field layout of the pad port.
// Assumes: Byte addresses on an 8-bit APB address, one aligned word each.
// Notes: Reserved bits are not stored and read as zero.
`ifndef GPM_REGS_SVH
`define GPM_REGS_SVH
`define GPM_PADS 15
`define GPM_OFS_DATA 8'h00
`define GPM_OFS_DIRECTION 8'h04
`define GPM_OFS_DRIVE 8'h0C
`define GPM_OFS_SENSE 8'h10
`define GPM_OFS_BOTH 8'h14
`define GPM_OFS_POLARITY 8'h18
`define GPM_OFS_MASK 8'h1C
`define GPM_OFS_RAW_STATUS 8'h20
`define GPM_OFS_MASKED_STATUS 8'h24
`define GPM_OFS_IRQ_CLEAR 8'h28
`define GPM_OFS_FUNC_LOW 8'h2C
`define GPM_OFS_FUNC_HIGH 8'h30
`define GPM_OFS_SET 8'h3C
`define GPM_OFS_CLEAR 8'h40
`define GPM_OFS_ROUTING 8'h44
`define GPM_FUNC_W 3
`define GPM_NIBBLE 4
`define GPM_PADS_PER_WORD 8
`define GPM_ROUTE_W 8
`define GPM_FUNC_GPIO 3'h0
`define GPM_FUNC_SERIAL_FUNCTION_1 3'h1
`define GPM_FUNC_SERIAL_FUNCTION_0 3'h4
`define GPM_FUNC_SERIAL_FUNCTION_2 3'h5
`define GPM_FUNC_LOW_MASK 32'h77777777
`define GPM_FUNC_HIGH_MASK 32'h07777777
`define GPM_RST_FUNC_LOW 32'h00000000
`define GPM_RST_FUNC_HIGH 32'h00000110
`define GPM_RST_ROUTING 32'h00000000
`endif

//--- core/gpm_pkg.sv
// Purpose: Types shared by the pad port modules.
// Assumes: Pad count fixed by the register header.
// Notes: The whole register state of the top is one packed struct.
`include "gpm_regs.svh"
package gpm_pkg;
    typedef logic [`GPM_PADS-1:0] gpm_pads_t;
    typedef struct packed {
        gpm_pads_t data;
        gpm_pads_t direction;
        gpm_pads_t drive;
        gpm_pads_t sense;
        gpm_pads_t both;
        gpm_pads_t polarity;
        gpm_pads_t mask;
        logic [31:0] func_low;
        logic [31:0] func_high;
        logic [31:0] routing;
        logic [31:0] prdata;
        logic pslverr;
        gpm_pads_t pad_out;
        gpm_pads_t pad_oe;
        logic [3:0] timer_in;
    } gpm_state_t;
endpackage

//--- core/gpm_sync.sv
// Purpose: Two-flop synchroniser for the pad inputs.
// Assumes: Inputs asynchronous to i_mclk.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ns
module gpm_sync #(
    parameter int W = 15
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } gpm_sync_state_t;

    gpm_sync_state_t st;
    gpm_sync_state_t next_st;

    if (W < 1) begin : g_bad_width
        $error("gpm_sync: width must be at least one");
    end

    always_comb begin
        next_st = st;
        next_st.s1 = i_d;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_q = st.s2;
endmodule

//--- core/gpm_irq_detect.sv
// Purpose: Per-pad edge or level interrupt detection; edge-mode pending bits are sticky.
// Assumes: Levels already synchronised; clear is a one-cycle bit pulse.
// Notes: First cycle after reset only primes the edge history.
`timescale 1ns/1ns
module gpm_irq_detect #(
    parameter int W = 15
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Pad levels and configuration
    input wire logic [W-1:0] i_level,
    input wire logic [W-1:0] i_sense,
    input wire logic [W-1:0] i_both,
    input wire logic [W-1:0] i_polarity,
    input wire logic [W-1:0] i_clear,
    // Pending conditions
    output logic [W-1:0] o_pending
);
    typedef struct packed {
        logic armed;
        logic [W-1:0] prev;
        logic [W-1:0] pending;
    } gpm_det_state_t;

    gpm_det_state_t st;
    gpm_det_state_t next_st;
    logic [W-1:0] level_hit;
    logic [W-1:0] edge_hit;

    if (W < 1) begin : g_bad_width
        $error("gpm_irq_detect: width must be at least one");
    end

    always_comb begin
        next_st = st;
        level_hit = ~(i_polarity ^ i_level);
        edge_hit = (i_both & (i_level ^ st.prev))
            | (~i_both & i_polarity & i_level & ~st.prev)
            | (~i_both & ~i_polarity & ~i_level & st.prev);
        next_st.prev = i_level;
        next_st.armed = 1'b1;
        if (st.armed) begin
            // Level mode follows the pad; edge mode holds, set beats clear
            next_st.pending = (i_sense & level_hit)
                | (~i_sense & (edge_hit | (st.pending & ~i_clear)));
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_pending = st.pending;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    for (genvar b = 0; b < W; b++) begin : g_chk
        a_level_follow: assert property (st.armed && i_sense[b] && level_hit[b]
            |=> o_pending[b]) else $error("level pending not raised");
        a_edge_latch: assert property (st.armed && !i_sense[b] && o_pending[b]
            && !i_clear[b] |=> o_pending[b]) else $error("edge pending lost");
        a_clear_works: assert property (st.armed && !i_sense[b] && i_clear[b]
            && !edge_hit[b] |=> !o_pending[b]) else $error("clear ignored");
    end
endmodule

//--- verification/gpm_pad_model.sv
// Purpose: Pads and serial peripherals at the far side of the port.
// Assumes: Pads are strong-driven by the outside world when not driven by the port.
// Notes: Serial patterns differ per function so each code is recognisable.
`timescale 1ns/1ns
module gpm_pad_model
    import gpm_pkg::*;
(
    // Port side of the pads
    input wire gpm_pads_t i_pad_out,
    input wire gpm_pads_t i_pad_oe,
    input wire gpm_pads_t i_ext,
    output wire gpm_pads_t o_pad_in,
    // Serial peripherals
    output wire gpm_pads_t o_s0_out,
    output wire gpm_pads_t o_s0_oe,
    output wire gpm_pads_t o_s1_out,
    output wire gpm_pads_t o_s1_oe,
    output wire gpm_pads_t o_s2_out,
    output wire gpm_pads_t o_s2_oe
);
    // Port wins where it drives; outside level elsewhere
    assign o_pad_in = (i_pad_oe & i_pad_out) | (~i_pad_oe & i_ext);
    assign o_s0_out = 15'h7FFF;
    assign o_s0_oe = 15'h7FFF;
    assign o_s1_out = 15'h0000;
    assign o_s1_oe = 15'h7FFF;
    assign o_s2_out = 15'h7FFF;
    assign o_s2_oe = 15'h0000;
endmodule

//--- verification/testbench.sv
// Purpose: Register-level test of the pad port over APB.
// Assumes: Pads 0-3 stay inputs for interrupt tests.
// Notes: Fixed waits cover the two-flop sync plus pending stage.
`timescale 1ns/1ns
`include "gpm_regs.svh"
module testbench
    import gpm_pkg::*;
();
    logic i_mclk, i_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_irq, err;
    logic [7:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd;
    gpm_pads_t pad_in, pad_out, pad_oe, drive_high, ext, lvl;
    gpm_pads_t s0_out, s0_oe, s1_out, s1_oe, s2_out, s2_oe;
    logic t1a, t1b, t2a, t2b;
    int bad_count, tests_run;
    logic [7:0] offs [10] = '{8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h24, 8'h2C, 8'h30, 8'h44,
        8'h04};
    logic [31:0] rv [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h00000110,
        32'h0, 32'h0};

    gpm_gpio_port u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_pad_in(pad_in),
        .o_pad_out(pad_out), .o_pad_oe(pad_oe), .o_pad_drive_high(drive_high),
        .i_serial_function_0_out(s0_out), .i_serial_function_0_oe(s0_oe), .i_serial_function_1_out(s1_out),
        .i_serial_function_1_oe(s1_oe), .i_serial_function_2_out(s2_out), .i_serial_function_2_oe(s2_oe), .o_pad_level(lvl),
        .o_timer1_input_a(t1a), .o_timer1_input_b(t1b), .o_timer2_input_a(t2a),
        .o_timer2_input_b(t2b), .o_irq(o_irq));

    gpm_pad_model u_pads (.i_pad_out(pad_out), .i_pad_oe(pad_oe), .i_ext(ext),
        .o_pad_in(pad_in), .o_s0_out(s0_out), .o_s0_oe(s0_oe), .o_s1_out(s1_out),
        .o_s1_oe(s1_oe), .o_s2_out(s2_out), .o_s2_oe(s2_oe));

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    task automatic results();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; idle cycle between transfers keeps the driver simple
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (o_pready !== 1'b1) begin
            bad_count++;
            $display("[ERR] pready expected 1 seen %b", o_pready);
            results();
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask

    task automatic irq_after(input logic exp, input logic [31:0] st);
        repeat (5) @(posedge i_mclk);
        chk("irq", {31'h0, exp}, {31'h0, o_irq});
        rdchk("masked_status", `GPM_OFS_MASKED_STATUS, st);
    endtask

    initial begin
        bad_count = 0;
        tests_run = 0;
        i_rst = 1'b1;
        i_psel = 1'b0;
        i_penable = 1'b0;
        i_pwrite = 1'b0;
        i_paddr = 8'h00;
        i_pwdata = 32'h0;
        ext = 15'h0008;
        repeat (5) @(posedge i_mclk);
        i_rst <= 1'b0;
        for (int k = 0; k < 10; k++) begin
            rdchk("reset_value", offs[k], rv[k]);
        end
        chk("serial_function_1_oe", 32'h3, {30'h0, pad_oe[10:9]});
        apb(1'b1, `GPM_OFS_DRIVE, 32'h00005A5A);
        @(posedge i_mclk);
        chk("drive_high", 32'h5A5A, {17'h0, drive_high});
        // Pads 0,1 rising/high; pad 2 both edges; pad 1 level; pad 0 masked off
        apb(1'b1, `GPM_OFS_POLARITY, 32'h3);
        apb(1'b1, `GPM_OFS_BOTH, 32'h4);
        apb(1'b1, `GPM_OFS_SENSE, 32'h2);
        apb(1'b1, `GPM_OFS_MASK, 32'hE);
        ext[0] <= 1'b1;
        irq_after(1'b0, 32'h0);
        apb(1'b1, `GPM_OFS_MASK, 32'hF);
        irq_after(1'b1, 32'h1);
        apb(1'b1, `GPM_OFS_IRQ_CLEAR, 32'h0);
        irq_after(1'b1, 32'h1);
        apb(1'b1, `GPM_OFS_IRQ_CLEAR, 32'h1);
        irq_after(1'b0, 32'h0);
        ext[3] <= 1'b0;
        irq_after(1'b1, 32'h8);
        apb(1'b1, `GPM_OFS_IRQ_CLEAR, 32'h8);
        for (int k = 0; k < 2; k++) begin
            ext[2] <= ~ext[2];
            irq_after(1'b1, 32'h4);
            apb(1'b1, `GPM_OFS_IRQ_CLEAR, 32'h4);
        end
        ext[1] <= 1'b1;
        irq_after(1'b1, 32'h2);
        apb(1'b1, `GPM_OFS_IRQ_CLEAR, 32'h2);
        irq_after(1'b1, 32'h2);
        ext[1] <= 1'b0;
        irq_after(1'b0, 32'h0);
        apb(1'b1, `GPM_OFS_MASKED_STATUS, 32'h7FFF);
        rdchk("status_ro", `GPM_OFS_MASKED_STATUS, 32'h0);
        // Pad 9 still serial: set must not touch its data bit
        apb(1'b1, `GPM_OFS_DIRECTION, 32'h0270);
        apb(1'b1, `GPM_OFS_SET, 32'h0230);
        apb(1'b1, `GPM_OFS_CLEAR, 32'h0010);
        repeat (2) @(posedge i_mclk);
        chk("gpio_out", 32'h2, {29'h0, pad_out[6:4]});
        apb(1'b1, `GPM_OFS_FUNC_HIGH, 32'h02514000);
        ext[7] <= 1'b1;
        repeat (4) @(posedge i_mclk);
        chk("pad_oe", 32'h1A70, {17'h0, pad_oe});
        chk("pad_drive", 32'h0820, {17'h0, pad_out & pad_oe});
        rdchk("func_high", `GPM_OFS_FUNC_HIGH, 32'h02514000);
        rdchk("pad_read", `GPM_OFS_DATA, 32'h000008A1);
        chk("pad_level", 32'h8A1, {17'h0, lvl});
        apb(1'b1, `GPM_OFS_ROUTING, 32'h0B06FF04);
        repeat (3) @(posedge i_mclk);
        chk("timer_inputs", 32'h8, {28'h0, t2b, t2a, t1b, t1a});
        rdchk("routing", `GPM_OFS_ROUTING, 32'h0B06FF04);
        apb(1'b1, `GPM_OFS_FUNC_LOW, 32'h40000000);
        repeat (2) @(posedge i_mclk);
        chk("pad7_serial_function_0", 32'h3, {30'h0, pad_out[7], pad_oe[7]});
        rdchk("func_low", `GPM_OFS_FUNC_LOW, 32'h40000000);
        apb(1'b0, 8'h08, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        results();
    end
endmodule
